// file: uul_core.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module uul_core
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motion logic side.
  input wire logic op_enabled,
  input wire logic velocity_mode,
  input wire logic cycle_tick,
  input wire logic [31:0] actual_pos,
  input wire logic move_dir_pos,
  input wire logic target_valid,
  input wire logic [31:0] target_pos,
  input wire logic target_abs,
  // Limit switch pins.
  input wire logic limit_pos_pin,
  input wire logic limit_neg_pin,
  // Results.
  output logic target_commit,
  output logic target_reject,
  output logic [31:0] target_out,
  output logic move_pos_allow,
  output logic move_neg_allow,
  output logic status_warning,
  output logic [1:0] stop_req,
  output logic stop_to_disabled,
  output logic stop_to_quickstop,
  output logic [31:0] active_pos_unit,
  output logic [31:0] active_spd_unit,
  output logic signed [7:0] pos_exponent,
  output logic feed_used,
  output logic [63:0] pos_ratio_num,
  output logic [63:0] pos_ratio_den,
  output logic [31:0] speed_num,
  output logic [31:0] speed_den
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  localparam int NREG = 20;
  logic [31:0] regs_q [NREG];
  logic [31:0] pos_unit_q, spd_unit_q, pend_pos_q, pend_spd_q;
  logic pend_q;
  logic [1:0] lp_s1_q, lp_s2_q;

  // Maps a word index onto a storage slot, or -1 when unmapped.
  function automatic int slot_of(input logic [15:0] idx);
    case (idx)
      uul_pkg::IDX_ENC_INC: slot_of = 0;
      uul_pkg::IDX_MOT_REV: slot_of = 1;
      uul_pkg::IDX_GEAR_MOT: slot_of = 2;
      uul_pkg::IDX_GEAR_DRV: slot_of = 3;
      uul_pkg::IDX_FEED: slot_of = 4;
      uul_pkg::IDX_FEED_REV: slot_of = 5;
      uul_pkg::IDX_SPD_NUM: slot_of = 6;
      uul_pkg::IDX_SPD_DEN: slot_of = 7;
      uul_pkg::IDX_ACC_NUM: slot_of = 8;
      uul_pkg::IDX_ACC_DEN: slot_of = 9;
      uul_pkg::IDX_JRK_NUM: slot_of = 10;
      uul_pkg::IDX_JRK_DEN: slot_of = 11;
      uul_pkg::IDX_VEL_SCALE: slot_of = 12;
      uul_pkg::IDX_SW_MIN: slot_of = 13;
      uul_pkg::IDX_SW_MAX: slot_of = 14;
      uul_pkg::IDX_REACT: slot_of = 15;
      uul_pkg::IDX_CTRL: slot_of = 16;
      uul_pkg::IDX_POS_UNIT: slot_of = 17;
      uul_pkg::IDX_SPD_UNIT: slot_of = 18;
      uul_pkg::IDX_STATUS: slot_of = 19;
      default: slot_of = -1;
    endcase
  endfunction

  function automatic logic [31:0] reset_of(input int s);
    if (s == 13)
      reset_of = uul_pkg::SW_MIN_RST;
    else if (s == 14)
      reset_of = uul_pkg::SW_MAX_RST;
    else if (s == 15)
      reset_of = uul_pkg::REACT_RST;
    else if (s == 16)
      reset_of = '0;
    else
      reset_of = uul_pkg::ONE_RST;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held_q, w_held_q;
  logic [17:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  int wslot;
  logic [31:0] wmerged;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q;
  assign wslot = slot_of(awaddr_q[17:2]);

  // Byte lanes merge into the current value of the slot being written.
  always_comb
  begin
    logic [31:0] old;
    old = '0;
    if (wslot == 17)
      old = pend_pos_q;
    else if (wslot == 18)
      old = pend_spd_q;
    else if (wslot >= 0 && wslot < 17)
      old = regs_q[wslot[4:0]];
    for (int b = 0; b < 4; b++)
      wmerged[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : old[b*8 +: 8];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status slot is read only; unmapped writes answer with an error.
        s_axi_bresp <= (wslot < 0 || wslot == 19) ? 2'b10 : 2'b00;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration slots; the unit words live in a pending copy instead.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int i = 0; i < 17; i++)
        regs_q[i] <= reset_of(i);
    else if (wr_go && wslot >= 0 && wslot < 17)
      regs_q[wslot[4:0]] <= wmerged;
  end

  // ----------------------------------------------------------------
  // Unit words with deferred application
  // ----------------------------------------------------------------
  // Software writes land in the pending copy; the active copy follows only
  // outside operation enabled so a unit write never changes the units of a running move.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_pos_q <= uul_pkg::POS_UNIT_RST;
      pend_spd_q <= uul_pkg::SPD_UNIT_RST;
      pos_unit_q <= uul_pkg::POS_UNIT_RST;
      spd_unit_q <= uul_pkg::SPD_UNIT_RST;
      pend_q <= 1'b0;
    end
    else
    begin
      if (wr_go && wslot == 17)
        pend_pos_q <= wmerged & uul_pkg::POS_UNIT_MASK;
      if (wr_go && wslot == 18)
        pend_spd_q <= wmerged & uul_pkg::SPD_UNIT_MASK;
      if (wr_go && (wslot == 17 || wslot == 18))
        pend_q <= 1'b1;
      else if (!op_enabled)
      begin
        pos_unit_q <= pend_pos_q;
        spd_unit_q <= pend_spd_q;
        pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scaling factors
  // ----------------------------------------------------------------
  // Decoded from the published unit word so the flag never runs a cycle
  // ahead of the unit that software sees as active.
  logic [7:0] pos_code;
  assign pos_code = active_pos_unit[uul_pkg::UNIT_LSB +: 8];
  assign feed_used = pos_code == uul_pkg::U_DIMLESS ||
    pos_code == uul_pkg::U_METER || pos_code == uul_pkg::U_INCH ||
    pos_code == uul_pkg::U_FOOT;

  // Increments per user unit are enc*gear_mot*feed_rev over
  // mot_rev*gear_drv*feed, feed terms only when feed_used; the divide is left to the motion logic.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_ratio_num <= '0;
      pos_ratio_den <= '0;
      speed_num <= '0;
      speed_den <= '0;
      pos_exponent <= '0;
      active_pos_unit <= '0;
      active_spd_unit <= '0;
    end
    else
    begin
      pos_ratio_num <= feed_used ?
        64'(regs_q[0] * regs_q[2] * regs_q[5]) :
        64'(regs_q[0] * regs_q[2]);
      pos_ratio_den <= feed_used ?
        64'(regs_q[1] * regs_q[3] * regs_q[4]) :
        64'(regs_q[1] * regs_q[3]);
      pos_exponent <= $signed(pos_unit_q[uul_pkg::EXP_LSB +: 8]);
      active_pos_unit <= pos_unit_q;
      // Velocity mode ignores the speed word and uses its own scale.
      active_spd_unit <= velocity_mode ? uul_pkg::SPD_UNIT_RST :
        spd_unit_q;
      speed_num <= velocity_mode ? regs_q[12] : regs_q[6];
      speed_den <= velocity_mode ? uul_pkg::ONE_RST : regs_q[7];
    end
  end

  // ----------------------------------------------------------------
  // Limit switches
  // ----------------------------------------------------------------
  // Two-flop synchronisers for the switch pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lp_s1_q <= '0;
      lp_s2_q <= '0;
    end
    else
    begin
      lp_s1_q <= {limit_neg_pin, limit_pos_pin};
      lp_s2_q <= lp_s1_q;
    end
  end

  logic hw_en;
  logic [1:0] sw_hit, lim_act;
  logic signed [31:0] pos_s, min_s, max_s, tgt_s;
  assign hw_en = regs_q[16][uul_pkg::CTRL_HW_EN];
  assign pos_s = $signed(actual_pos);
  assign min_s = $signed(regs_q[13]);
  assign max_s = $signed(regs_q[14]);
  assign sw_hit = {pos_s < min_s, pos_s > max_s};
  assign lim_act = (hw_en ? lp_s2_q : 2'b00) | sw_hit;

  // One watcher per direction: on, then off, then recrossed clears warn.
  uul_pkg::uul_lw_e lw_q [2];
  logic [31:0] lw_pos_q [2];
  logic [1:0] lw_new;
  for (genvar d = 0; d < 2; d++)
  begin : g_watch
    logic back;
    // Position recrossed means moved back inside the trip point.
    assign back = (d == 0) ? (pos_s < $signed(lw_pos_q[d])) :
      (pos_s > $signed(lw_pos_q[d]));
    assign lw_new[d] = lim_act[d] && lw_q[d] == uul_pkg::UUL_LW_IDLE;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lw_q[d] <= uul_pkg::UUL_LW_IDLE;
        lw_pos_q[d] <= '0;
      end
      else
        case (lw_q[d])
          uul_pkg::UUL_LW_IDLE:
            if (lim_act[d])
            begin
              lw_q[d] <= uul_pkg::UUL_LW_ON;
              lw_pos_q[d] <= actual_pos;
            end
          uul_pkg::UUL_LW_ON:
            if (!lim_act[d])
              lw_q[d] <= uul_pkg::UUL_LW_OFF;
          uul_pkg::UUL_LW_OFF:
            if (lim_act[d])
              lw_q[d] <= uul_pkg::UUL_LW_ON;
            else if (back)
              lw_q[d] <= uul_pkg::UUL_LW_IDLE;
          default: lw_q[d] <= uul_pkg::UUL_LW_IDLE;
        endcase
    end
  end

  assign status_warning = lw_q[0] != uul_pkg::UUL_LW_IDLE ||
    lw_q[1] != uul_pkg::UUL_LW_IDLE;
  assign move_pos_allow = !lim_act[0];
  assign move_neg_allow = !lim_act[1];

  // Reaction pulse on each fresh trip of a switch when the reaction code is one of the four stop codes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stop_req <= uul_pkg::UUL_STOP_NONE;
      stop_to_disabled <= 1'b0;
      stop_to_quickstop <= 1'b0;
    end
    else
    begin
      stop_req <= uul_pkg::UUL_STOP_NONE;
      stop_to_disabled <= 1'b0;
      stop_to_quickstop <= 1'b0;
      if (|lw_new)
        case (regs_q[15])
          uul_pkg::R_SLOW_OFF, uul_pkg::R_SLOW_QS:
          begin
            stop_req <= uul_pkg::UUL_STOP_SLOW;
            stop_to_disabled <= regs_q[15] == uul_pkg::R_SLOW_OFF;
            stop_to_quickstop <= regs_q[15] == uul_pkg::R_SLOW_QS;
          end
          uul_pkg::R_QUICK_OFF, uul_pkg::R_QUICK_QS:
          begin
            stop_req <= uul_pkg::UUL_STOP_QUICK;
            stop_to_disabled <= regs_q[15] == uul_pkg::R_QUICK_OFF;
            stop_to_quickstop <= regs_q[15] == uul_pkg::R_QUICK_QS;
          end
          default: stop_req <= uul_pkg::UUL_STOP_NONE;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Target commit on the cycle tick
  // ----------------------------------------------------------------
  logic tgt_up;
  assign tgt_s = $signed(target_pos);
  assign tgt_up = target_abs ? (tgt_s > pos_s) : move_dir_pos;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      target_commit <= 1'b0;
      target_reject <= 1'b0;
      target_out <= '0;
    end
    else
    begin
      target_commit <= 1'b0;
      target_reject <= 1'b0;
      if (cycle_tick && target_valid)
      begin
        if ((tgt_up && lim_act[0]) || (!tgt_up && lim_act[1]))
          target_reject <= 1'b1;
        else
        begin
          target_commit <= 1'b1;
          if (!target_abs)
            target_out <= target_pos;
          else if (tgt_s > max_s)
            target_out <= regs_q[14];
          else if (tgt_s < min_s)
            target_out <= regs_q[13];
          else
            target_out <= target_pos;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  int rslot;
  assign rslot = slot_of(s_axi_araddr[17:2]);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rslot < 0 ? 2'b10 : 2'b00;
      if (rslot == 17)
        s_axi_rdata <= pend_pos_q;
      else if (rslot == 18)
        s_axi_rdata <= pend_spd_q;
      else if (rslot == 19)
        s_axi_rdata <= {24'h000000, status_warning, 3'b000, pend_q,
          sw_hit != 2'b00, lim_act};
      else if (rslot >= 0)
        s_axi_rdata <= regs_q[rslot[4:0]];
      else
        s_axi_rdata <= '0;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// file: uul_pkg.sv
package uul_pkg;
  // Register word indices (printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it).
  localparam logic [15:0] IDX_POS_UNIT = 16'h60a8;
  localparam logic [15:0] IDX_SPD_UNIT = 16'h60a9;
  localparam logic [15:0] IDX_ENC_INC = 16'h60e6;
  localparam logic [15:0] IDX_MOT_REV = 16'h60eb;
  localparam logic [15:0] IDX_GEAR_MOT = 16'h60e8;
  localparam logic [15:0] IDX_GEAR_DRV = 16'h60ed;
  localparam logic [15:0] IDX_FEED = 16'h60e9;
  localparam logic [15:0] IDX_FEED_REV = 16'h60ee;
  localparam logic [15:0] IDX_SPD_NUM = 16'h6096;
  localparam logic [15:0] IDX_SPD_DEN = 16'h6196;
  localparam logic [15:0] IDX_ACC_NUM = 16'h6097;
  localparam logic [15:0] IDX_ACC_DEN = 16'h6197;
  localparam logic [15:0] IDX_JRK_NUM = 16'h60a2;
  localparam logic [15:0] IDX_JRK_DEN = 16'h61a2;
  localparam logic [15:0] IDX_VEL_SCALE = 16'h604c;
  localparam logic [15:0] IDX_SW_MIN = 16'h607d;
  localparam logic [15:0] IDX_SW_MAX = 16'h617d;
  localparam logic [15:0] IDX_REACT = 16'h3701;
  localparam logic [15:0] IDX_CTRL = 16'h3702;
  localparam logic [15:0] IDX_STATUS = 16'h3703;
  localparam int ADDR_W = 18;
  // Reset values.
  localparam logic [31:0] POS_UNIT_RST = 32'hff410000;
  localparam logic [31:0] SPD_UNIT_RST = 32'h00b44700;
  localparam logic [31:0] ONE_RST = 32'h00000001;
  localparam logic [31:0] REACT_RST = 32'hffffffff;
  localparam logic [31:0] SW_MIN_RST = 32'h80000000;
  localparam logic [31:0] SW_MAX_RST = 32'h7fffffff;
  // Field layout.
  localparam int EXP_LSB = 24;
  localparam int UNIT_LSB = 16;
  localparam int TIME_LSB = 8;
  localparam logic [31:0] POS_UNIT_MASK = 32'hffff0000;
  localparam logic [31:0] SPD_UNIT_MASK = 32'hffffff00;
  // Unit codes that take the feed constant into account.
  localparam logic [7:0] U_DIMLESS = 8'h00;
  localparam logic [7:0] U_METER = 8'h01;
  localparam logic [7:0] U_INCH = 8'hc1;
  localparam logic [7:0] U_FOOT = 8'hc2;
  // Reaction codes.
  localparam logic [31:0] R_NONE = 32'hffffffff;
  localparam logic [31:0] R_SLOW_OFF = 32'h00000001;
  localparam logic [31:0] R_QUICK_OFF = 32'h00000002;
  localparam logic [31:0] R_SLOW_QS = 32'h00000005;
  localparam logic [31:0] R_QUICK_QS = 32'h00000006;
  // Control and status bit positions.
  localparam int CTRL_HW_EN = 0;
  localparam int STAT_WARN = 7;
  localparam int STAT_LIM_POS = 0;
  localparam int STAT_LIM_NEG = 1;
  localparam int STAT_OUTSIDE = 2;
  localparam int STAT_PENDING = 3;
  // Stop request encodings.
  typedef enum logic [1:0]
  {
    UUL_STOP_NONE = 2'b00,
    UUL_STOP_SLOW = 2'b01,
    UUL_STOP_QUICK = 2'b10
  } uul_stop_e;
  // Limit watch states.
  typedef enum logic [1:0]
  {
    UUL_LW_IDLE = 2'b00,
    UUL_LW_ON = 2'b01,
    UUL_LW_OFF = 2'b10
  } uul_lw_e;
endpackage

// file: uul_core_sva.sv
`timescale 1ns/1ps
module uul_core_sva
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Motion logic side.
  input wire logic op_enabled,
  input wire logic cycle_tick,
  input wire logic target_valid,
  // Results.
  input wire logic target_commit,
  input wire logic target_reject,
  input wire logic move_pos_allow,
  input wire logic move_neg_allow,
  input wire logic status_warning,
  input wire logic [1:0] stop_req,
  input wire logic stop_to_disabled,
  input wire logic stop_to_quickstop,
  input wire logic [31:0] active_pos_unit,
  input wire logic [31:0] active_spd_unit,
  input wire logic signed [7:0] pos_exponent,
  input wire logic feed_used
);
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Length units pick up the feed constant, angular units do not.
  logic len_unit;
  assign len_unit = active_pos_unit[23:16] inside {uul_pkg::U_DIMLESS,
    uul_pkg::U_METER, uul_pkg::U_INCH, uul_pkg::U_FOOT};

  chk_target_answer:
  assert property (cycle_tick && target_valid |=> target_commit ^ target_reject)
    else $error("Offered target got no single answer.");
  chk_no_stray:
  assert property (!(cycle_tick && target_valid)
    |=> !target_commit && !target_reject)
    else $error("Target answer without an offer.");
  chk_stop_warn:
  assert property (stop_req != 2'b00 |-> ##[0:1] status_warning)
    else $error("Stop request without warning flag.");
  chk_stop_pulse:
  assert property (stop_req != 2'b00 |=> stop_req == 2'b00)
    else $error("Stop request longer than one cycle.");
  chk_stop_with_kind:
  assert property ((stop_req != 2'b00) == (stop_to_disabled || stop_to_quickstop))
    else $error("Stop request and end state disagree.");
  chk_stop_one_kind:
  assert property (stop_req != 2'b00 |-> stop_to_disabled ^ stop_to_quickstop)
    else $error("Stop must end in exactly one state.");
  chk_block_warn:
  assert property ($fell(move_pos_allow) || $fell(move_neg_allow)
    |-> ##[0:2] status_warning)
    else $error("Blocked direction without warning flag.");
  chk_exp_track:
  assert property ($stable(active_pos_unit)
    |-> pos_exponent == active_pos_unit[31:24])
    else $error("Exponent does not follow the unit word.");
  chk_feed_units:
  assert property ($stable(active_pos_unit) |-> feed_used == len_unit)
    else $error("Feed constant use does not match the unit.");
  chk_unit_frozen:
  assert property (op_enabled && $past(aresetn)
    |=> $stable(active_pos_unit) && $stable(active_spd_unit))
    else $error("Unit word changed while operation enabled.");

  // Main scenarios seen at least once.
  cov_commit: cover property (target_commit);
  cov_reject: cover property (target_reject);
  cov_slow: cover property (stop_req == 2'b01);
  cov_quick: cover property (stop_req == 2'b10);
endmodule

bind uul_core uul_core_sva uul_core_sva_i (.*);

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic aclk, aresetn;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic op_enabled, velocity_mode, cycle_tick, move_dir_pos;
  logic target_valid, target_abs, limit_pos_pin, limit_neg_pin;
  logic [31:0] actual_pos, target_pos, target_out;
  logic target_commit, target_reject, move_pos_allow, move_neg_allow;
  logic status_warning, stop_to_disabled, stop_to_quickstop, feed_used;
  logic [1:0] stop_req;
  logic [31:0] active_pos_unit, active_spd_unit, speed_num, speed_den;
  logic signed [7:0] pos_exponent;
  logic [63:0] pos_ratio_num, pos_ratio_den;
  logic [1:0] tick_n = 2'd0;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] codes [5] = '{32'hffffffff, 32'h1, 32'h2, 32'h5, 32'h6};
  logic [1:0] exp_stop [5] = '{2'd0, 2'd1, 2'd2, 2'd1, 2'd2};
  logic [1:0] exp_end [5] = '{2'd0, 2'd2, 2'd2, 2'd1, 2'd1};

  uul_core uul_core_i (.*);

  // Clock of 100 ns period.
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Control-cycle strobe every fourth clock, so target offers see real ticks.
  always @(posedge aclk)
  begin
    tick_n <= tick_n + 2'd1;
    cycle_tick <= (tick_n == 2'd3);
  end

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One clock of a bounded wait; a hang ends the run as a mismatch.
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200)
    begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask

  // Readies are looked at just after an edge, when they have settled.
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      #1;
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs)
        cmp(32'(s_axi_bresp), 32'(er));
      step(n);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
      if (b_hs)
        s_axi_bready <= 1'b0;
    end while (!b_hs);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      #1;
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs)
      begin
        cmp(s_axi_rdata, e);
        cmp(32'(s_axi_rresp), 32'(er));
      end
      step(n);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
      if (r_hs)
        s_axi_rready <= 1'b0;
    end while (!r_hs);
  endtask

  // Offer one target and wait for commit or reject.
  task automatic offer(input logic [31:0] p, input logic ab, input logic dir,
                       input logic ec, input logic [31:0] eo);
    int n;
    logic c, r;
    n = 0;
    @(posedge aclk);
    target_pos <= p;
    target_abs <= ab;
    move_dir_pos <= dir;
    target_valid <= 1'b1;
    do
    begin
      step(n);
      #1;
      c = target_commit;
      r = target_reject;
    end while (!c && !r);
    cmp(32'(c), 32'(ec));
    if (ec && ab)
      cmp(target_out, eo);
    @(posedge aclk);
    target_valid <= 1'b0;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    logic [1:0] got, fin;
    {aresetn, op_enabled, velocity_mode, cycle_tick, move_dir_pos} = '0;
    {target_valid, target_abs, limit_pos_pin, limit_neg_pin} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    actual_pos = '0;
    target_pos = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    idle(2);
    rd_chk(uul_pkg::IDX_POS_UNIT, 32'hff410000, 2'b00);
    rd_chk(uul_pkg::IDX_SPD_UNIT, 32'h00b44700, 2'b00);
    rd_chk(uul_pkg::IDX_REACT, 32'hffffffff, 2'b00);
    cmp({24'h0, pos_exponent}, 32'hff);
    axi_wr(uul_pkg::IDX_POS_UNIT, 32'hffffffff, 2'b00);
    rd_chk(uul_pkg::IDX_POS_UNIT, 32'hffff0000, 2'b00);
    axi_wr(uul_pkg::IDX_SPD_UNIT, 32'hffffffff, 2'b00);
    rd_chk(uul_pkg::IDX_SPD_UNIT, 32'hffffff00, 2'b00);
    rd_chk(16'h0000, 32'h0, 2'b10);
    axi_wr(uul_pkg::IDX_STATUS, 32'h1, 2'b10);
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(uul_pkg::IDX_ACC_NUM + 16'(i * 256), 32'(i + 2), 2'b00);
      rd_chk(uul_pkg::IDX_ACC_NUM + 16'(i * 256), 32'(i + 2), 2'b00);
    end
    rd_chk(uul_pkg::IDX_JRK_DEN, 32'h1, 2'b00);
    // Unit words written while enabled stay pending; speed factors apply at once.
    @(posedge aclk);
    op_enabled <= 1'b1;
    axi_wr(uul_pkg::IDX_POS_UNIT, 32'hfd010000, 2'b00);
    axi_wr(uul_pkg::IDX_SPD_UNIT, 32'hfd010300, 2'b00);
    axi_wr(uul_pkg::IDX_SPD_NUM, 32'h3, 2'b00);
    axi_wr(uul_pkg::IDX_SPD_DEN, 32'h7, 2'b00);
    idle(4);
    cmp(active_pos_unit, 32'hffff0000);
    @(posedge aclk);
    op_enabled <= 1'b0;
    idle(4);
    cmp(active_pos_unit, 32'hfd010000);
    cmp({24'h0, pos_exponent}, 32'hfd);
    cmp(32'(feed_used), 32'h1);
    cmp(active_spd_unit, 32'hfd010300);
    cmp(speed_num, 32'h3);
    cmp(speed_den, 32'h7);
    @(posedge aclk);
    velocity_mode <= 1'b1;
    idle(4);
    cmp(active_spd_unit, 32'h00b44700);
    axi_wr(uul_pkg::IDX_VEL_SCALE, 32'h5, 2'b00);
    rd_chk(uul_pkg::IDX_VEL_SCALE, 32'h5, 2'b00);
    @(posedge aclk);
    velocity_mode <= 1'b0;
    axi_wr(uul_pkg::IDX_POS_UNIT, 32'hff410000, 2'b00);
    idle(4);
    cmp(32'(feed_used), 32'h0);
    // Software limits of -100 and 1000.
    axi_wr(uul_pkg::IDX_SW_MIN, 32'hffffff9c, 2'b00);
    axi_wr(uul_pkg::IDX_SW_MAX, 32'h000003e8, 2'b00);
    idle(2);
    offer(32'h00001388, 1'b1, 1'b1, 1'b1, 32'h000003e8);
    offer(32'hfffffe0c, 1'b1, 1'b0, 1'b1, 32'hffffff9c);
    offer(32'h000000c8, 1'b1, 1'b1, 1'b1, 32'h000000c8);
    @(posedge aclk);
    actual_pos <= 32'h000007d0;
    idle(4);
    offer(32'h0000000a, 1'b0, 1'b1, 1'b0, 32'h0);
    offer(32'h0000000a, 1'b0, 1'b0, 1'b1, 32'h0);
    @(posedge aclk);
    actual_pos <= 32'h0;
    idle(4);
    cmp(32'(status_warning), 32'h0);
    // Pins are ignored until enabled in the control register.
    axi_wr(uul_pkg::IDX_REACT, 32'h1, 2'b00);
    limit_pos_pin <= 1'b1;
    idle(10);
    cmp(32'(move_pos_allow), 32'h1);
    cmp(32'(status_warning), 32'h0);
    limit_pos_pin <= 1'b0;
    axi_wr(uul_pkg::IDX_CTRL, 32'h1, 2'b00);
    for (int i = 0; i < 5; i++)
    begin
      axi_wr(uul_pkg::IDX_REACT, codes[i], 2'b00);
      actual_pos <= 32'h00000064;
      idle(4);
      limit_pos_pin <= 1'b1;
      got = 2'b00;
      fin = 2'b00;
      repeat (20)
      begin
        idle(1);
        if (stop_req !== 2'b00)
        begin
          got = stop_req;
          fin = {stop_to_disabled, stop_to_quickstop};
        end
      end
      cmp(32'(got), 32'(exp_stop[i]));
      cmp(32'(fin), 32'(exp_end[i]));
      cmp(32'(move_pos_allow), 32'h0);
      cmp(32'(move_neg_allow), 32'h1);
      cmp(32'(status_warning), 32'h1);
      rd_chk(uul_pkg::IDX_STATUS, 32'h00000081, 2'b00);
      limit_pos_pin <= 1'b0;
      idle(8);
      cmp(32'(move_pos_allow), 32'h1);
      cmp(32'(status_warning), 32'h1);
      actual_pos <= 32'h00000032;
      idle(8);
      cmp(32'(status_warning), 32'h0);
    end
    limit_neg_pin <= 1'b1;
    idle(8);
    cmp(32'(move_neg_allow), 32'h0);
    cmp(32'(move_pos_allow), 32'h1);
    wrap_up();
  end
endmodule
